// *** src/host_reg_pkg.sv ***
// Constants shared by the host register front end
package host_reg_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int EVENT_W = 16;
    localparam int OFS_W = 11;
    localparam int CFG_OFS_W = 8;
    localparam int BAR_LSB = 11;
    localparam int BAR_W = DATA_W - BAR_LSB;

    // ------------------------------------------------------------
    // Host accessible register offsets (bytes from the base address)
    // ------------------------------------------------------------
    localparam logic [OFS_W-1:0] OFS_SOFTWARE_RESET_CONTROL = 11'h000;
    localparam logic [OFS_W-1:0] OFS_INTERRUPT_ENABLE_MASK = 11'h004;
    localparam logic [OFS_W-1:0] OFS_INTERRUPT_STATUS = 11'h008;

    // ------------------------------------------------------------
    // Configuration space offsets
    // ------------------------------------------------------------
    localparam logic [CFG_OFS_W-1:0] CFG_OFS_IDENT = 8'h00;
    localparam logic [CFG_OFS_W-1:0] CFG_OFS_COMMAND = 8'h04;
    localparam logic [CFG_OFS_W-1:0] CFG_OFS_CLASS = 8'h08;
    localparam logic [CFG_OFS_W-1:0] CFG_OFS_MEM_BASE = 8'h10;
    localparam logic [CFG_OFS_W-1:0] CFG_OFS_INTR = 8'h3c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 15;
    localparam int CMD_MEM_ENABLE_BIT = 1;
    localparam int INTR_LINE_W = 8;
    localparam int INTR_PIN_LSB = 8;
    localparam logic [INTR_LINE_W-1:0] INTR_PIN_VALUE = 8'h02;
    localparam int SYSTEM_ERROR_BIT = 0;
    localparam int PARITY_ERROR_BIT = 1;
    localparam logic [EVENT_W-1:0] ENABLE_RESET = 16'h0000;
    localparam logic [BAR_W-1:0] BAR_RESET = 21'h000000;
    localparam logic [INTR_LINE_W-1:0] INTR_LINE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TX_FORCED_HIGH = 32'hffffffff;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

endpackage

// *** src/event_flag_cell.sv ***
// One sticky event flag: set wins over clear
module event_flag_cell (
    input wire logic mclk,
    input wire logic reset,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);
    logic flag_d;

    // An event in the clearing cycle is kept, so no event is lost
    assign flag_d = set ? 1'b1 : (clear ? 1'b0 : flag_q);

    always_ff @(posedge mclk) begin
        if (reset) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
endmodule // event_flag_cell

// *** src/host_register_front.sv ***
// Host register front end: software reset, interrupt enable and status, config space
//
// Notes on behaviour
// - Config registers answer only to a configuration cycle with the select input high.
// - Writes to unused bits do nothing; unused bits read as zero here.
// - Writable configuration bits read back the value last written.
// - Writable bits reset to zero unless a register says otherwise.
// - Writes to read-only positions leave operation unchanged.
// - Any asserted byte enable writes all 32 bits; none asserted touches nothing.
// - Memory space registers decode at their offset added to the programmed memory base address.
// - Soft reset bit 15 holds all but the host interface in reset.
// - Soft reset bit never clears itself; host writes zero to release.
// - Hardware reset clears the soft reset bit.
// - During soft reset host pins stay driven and transmit data is forced high.
// - Soft reset restores all registers except the soft reset bit and the configuration registers.
// - Enable register holds sixteen read/write enables in bits 15 to 0.
// - Enable bit 0 passes system error events to the interrupt output.
// - Enable bit 1 passes parity error events to the interrupt output.
// - A cleared enable only masks; the status bit still records the event.
// - Read-only status at offset 0x008 mirrors enable bit positions.
module host_register_front
    import host_reg_pkg::*;
#(
    // Identification values are arbitrary
    parameter logic [15:0] VENDOR_CODE = 16'h1a2b,
    parameter logic [15:0] DEVICE_CODE = 16'h3c4d,
    parameter logic [31:0] CLASS_REVISION = 32'h02800001
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_config,
    input wire logic req_idsel,
    input wire logic req_write,
    input wire logic [DATA_W-1:0] req_addr,
    input wire logic [BE_W-1:0] host_byte_enables_n,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [EVENT_W-1:0] event_in,
    input wire logic [DATA_W-1:0] tx_link_data_in,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic host_interrupt_out,
    output logic host_interrupt_oe_n,
    output logic core_reset_out,
    output logic [DATA_W-1:0] tx_link_data_out
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic soft_reset_q;
    logic soft_reset_d;
    logic [EVENT_W-1:0] enable_q;
    logic [EVENT_W-1:0] enable_d;
    logic [EVENT_W-1:0] status_q;
    logic [BAR_W-1:0] bar_q;
    logic [BAR_W-1:0] bar_d;
    logic mem_enable_q;
    logic mem_enable_d;
    logic [INTR_LINE_W-1:0] intr_line_q;
    logic [INTR_LINE_W-1:0] intr_line_d;
    logic rsp_valid_q;
    logic rsp_valid_d;
    logic [DATA_W-1:0] rsp_rdata_q;
    logic [DATA_W-1:0] rsp_rdata_d;
    logic irq_n_q;
    logic irq_n_d;
    logic core_reset_q;
    logic core_reset_d;
    logic [DATA_W-1:0] tx_q;
    logic [DATA_W-1:0] tx_d;

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire any_be = ~&host_byte_enables_n;
    wire cfg_hit = req_valid & req_config & req_idsel;
    wire [BAR_W-1:0] addr_base = req_addr[DATA_W-1:BAR_LSB];
    wire mem_hit = req_valid & ~req_config & mem_enable_q & (addr_base == bar_q);
    wire [OFS_W-1:0] mem_ofs = {req_addr[OFS_W-1:2], 2'b00};
    wire [CFG_OFS_W-1:0] cfg_ofs = {req_addr[CFG_OFS_W-1:2], 2'b00};
    wire any_hit = mem_hit | cfg_hit;
    wire do_write = any_hit & req_write & any_be;
    wire do_read = any_hit & ~req_write & any_be;

    // ------------------------------------------------------------
    // Memory space selects
    // ------------------------------------------------------------
    wire sel_soft_reset = mem_hit & (mem_ofs == OFS_SOFTWARE_RESET_CONTROL);
    wire sel_enable = mem_hit & (mem_ofs == OFS_INTERRUPT_ENABLE_MASK);
    wire sel_status = mem_hit & (mem_ofs == OFS_INTERRUPT_STATUS);

    // ------------------------------------------------------------
    // Configuration space selects
    // ------------------------------------------------------------
    wire sel_ident = cfg_hit & (cfg_ofs == CFG_OFS_IDENT);
    wire sel_command = cfg_hit & (cfg_ofs == CFG_OFS_COMMAND);
    wire sel_class = cfg_hit & (cfg_ofs == CFG_OFS_CLASS);
    wire sel_mem_base = cfg_hit & (cfg_ofs == CFG_OFS_MEM_BASE);
    wire sel_intr = cfg_hit & (cfg_ofs == CFG_OFS_INTR);

    // ------------------------------------------------------------
    // Write and read strobes
    // ------------------------------------------------------------
    // Status is read-only, a write there has no target
    wire wr_soft_reset = do_write & sel_soft_reset;
    wire wr_enable = do_write & sel_enable;
    wire wr_command = do_write & sel_command;
    wire wr_mem_base = do_write & sel_mem_base;
    wire wr_intr = do_write & sel_intr;
    wire rd_status = do_read & sel_status;

    // Soft reset reaches everything behind the host interface
    wire func_reset = reset | soft_reset_q;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    // Field slices of the write word
    wire wr_soft_bit = req_wdata[SOFT_RESET_BIT];
    wire [EVENT_W-1:0] wr_enable_field = req_wdata[EVENT_W-1:0];
    wire [BAR_W-1:0] wr_base_field = req_wdata[DATA_W-1:BAR_LSB];
    wire wr_mem_enable_bit = req_wdata[CMD_MEM_ENABLE_BIT];
    wire [INTR_LINE_W-1:0] wr_line_field = req_wdata[INTR_LINE_W-1:0];

    // Bit stays until the host writes zero; only hardware reset clears it
    assign soft_reset_d = wr_soft_reset ? wr_soft_bit : soft_reset_q;
    // Whole word written, bits 31..16 dropped
    assign enable_d = wr_enable ? wr_enable_field : enable_q;
    assign bar_d = wr_mem_base ? wr_base_field : bar_q;
    assign mem_enable_d = wr_command ? wr_mem_enable_bit : mem_enable_q;
    assign intr_line_d = wr_intr ? wr_line_field : intr_line_q;

    // ------------------------------------------------------------
    // Host accessible registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= soft_reset_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (func_reset) begin
            enable_q <= ENABLE_RESET;
        end else begin
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt status flags
    // ------------------------------------------------------------
    // Status flags: events held off while the functional logic sits in reset.
    // Reading the status word clears it; an event in the same cycle survives.
    genvar gi;
    generate
        for (gi = 0; gi < EVENT_W; gi++) begin : g_flag
            event_flag_cell u_flag (
                .mclk(mclk),
                .reset(func_reset),
                .set(event_in[gi]),
                .clear(rd_status),
                .flag_q(status_q[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Configuration registers (survive soft reset)
    // ------------------------------------------------------------
    // Only hardware reset reaches these, so the host keeps its mapping
    // through a soft reset and can release it without reprogramming
    always_ff @(posedge mclk) begin
        if (reset) begin
            bar_q <= BAR_RESET;
        end else begin
            bar_q <= bar_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mem_enable_q <= 1'b0;
        end else begin
            mem_enable_q <= mem_enable_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            intr_line_q <= INTR_LINE_RESET;
        end else begin
            intr_line_q <= intr_line_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Unused bits read as zero, a choice the host must not rely on
    wire [DATA_W-1:0] rd_soft_reset = {{(DATA_W-SOFT_RESET_BIT-1){1'b0}}, soft_reset_q, {SOFT_RESET_BIT{1'b0}}};
    wire [DATA_W-1:0] rd_enable = {{(DATA_W-EVENT_W){1'b0}}, enable_q};
    wire [DATA_W-1:0] rd_status_word = {{(DATA_W-EVENT_W){1'b0}}, status_q};
    wire [DATA_W-1:0] rd_ident = {DEVICE_CODE, VENDOR_CODE};
    wire [DATA_W-1:0] rd_command = {{(DATA_W-CMD_MEM_ENABLE_BIT-1){1'b0}}, mem_enable_q, {CMD_MEM_ENABLE_BIT{1'b0}}};
    wire [DATA_W-1:0] rd_mem_base = {bar_q, {BAR_LSB{1'b0}}};
    wire [DATA_W-1:0] rd_intr = {{(DATA_W-INTR_PIN_LSB-INTR_LINE_W){1'b0}}, INTR_PIN_VALUE, intr_line_q};

    // Selects are one-hot or all low, so an AND-OR gives the read word
    wire [DATA_W-1:0] pick_soft_reset = {DATA_W{sel_soft_reset}} & rd_soft_reset;
    wire [DATA_W-1:0] pick_enable = {DATA_W{sel_enable}} & rd_enable;
    wire [DATA_W-1:0] pick_status = {DATA_W{sel_status}} & rd_status_word;
    wire [DATA_W-1:0] pick_ident = {DATA_W{sel_ident}} & rd_ident;
    wire [DATA_W-1:0] pick_command = {DATA_W{sel_command}} & rd_command;
    wire [DATA_W-1:0] pick_class = {DATA_W{sel_class}} & CLASS_REVISION;
    wire [DATA_W-1:0] pick_mem_base = {DATA_W{sel_mem_base}} & rd_mem_base;
    wire [DATA_W-1:0] pick_intr = {DATA_W{sel_intr}} & rd_intr;

    wire [DATA_W-1:0] rd_mux =
        pick_soft_reset |
        pick_enable |
        pick_status |
        pick_ident |
        pick_command |
        pick_class |
        pick_mem_base |
        pick_intr;

    // ------------------------------------------------------------
    // Response
    // ------------------------------------------------------------
    // Unclaimed addresses get no response, leaving the host to abort
    assign rsp_valid_d = any_hit;
    // No byte enable means no access, so the word comes back empty
    assign rsp_rdata_d = do_read ? rd_mux : READ_ZERO;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_valid_q <= 1'b0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rsp_rdata_q <= READ_ZERO;
        end else begin
            rsp_rdata_q <= rsp_rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt, core reset and transmit data
    // ------------------------------------------------------------
    wire irq_d = |(status_q & enable_q);
    // Pin enable is kept inverted in its flop so the output needs no gate
    assign irq_n_d = ~irq_d;
    assign core_reset_d = soft_reset_q;
    // Forcing at the flop keeps the link pins free of glitches as reset lands
    assign tx_d = soft_reset_q ? TX_FORCED_HIGH : tx_link_data_in;

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_n_q <= 1'b1;
        end else begin
            irq_n_q <= irq_n_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            core_reset_q <= 1'b1;
        end else begin
            core_reset_q <= core_reset_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_q <= TX_FORCED_HIGH;
        end else begin
            tx_q <= tx_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open-drain interrupt: level always low, enable carries the state.
    // It stays released in soft reset because the enables and status flags are held in reset.
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rsp_rdata_q;
    assign host_interrupt_out = 1'b0;
    assign host_interrupt_oe_n = irq_n_q;
    assign core_reset_out = core_reset_q;
    assign tx_link_data_out = tx_q;

endmodule // host_register_front

// *** bench/host_props.sv ***
// Port level assertions for the host register front end
module host_props
    import host_reg_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_config,
    input wire logic req_idsel,
    input wire logic req_write,
    input wire logic [DATA_W-1:0] req_addr,
    input wire logic [BE_W-1:0] host_byte_enables_n,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [EVENT_W-1:0] event_in,
    input wire logic [DATA_W-1:0] tx_link_data_in,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    input wire logic host_interrupt_out,
    input wire logic host_interrupt_oe_n,
    input wire logic core_reset_out,
    input wire logic [DATA_W-1:0] tx_link_data_out
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    wire cfg_hit = req_valid && req_config && req_idsel;
    wire mem_wr = req_valid && req_write && !req_config;
    a_cfg_answer: assert property (cfg_hit |=> rsp_valid) else $error("config access not answered");
    a_cfg_refuse: assert property (req_valid && req_config && !req_idsel |=> !rsp_valid)
        else $error("config access without select answered");
    a_none_be_zero: assert property (cfg_hit && !req_write && host_byte_enables_n == 4'hf |=> rsp_rdata == READ_ZERO)
        else $error("read with no byte enable returned data");
    a_idle_rdata: assert property (!rsp_valid |-> rsp_rdata == READ_ZERO) else $error("read data without answer");
    a_tx_forced: assert property (core_reset_out && $past(core_reset_out) |-> tx_link_data_out == TX_FORCED_HIGH)
        else $error("transmit data not high in reset");
    a_tx_pass: assert property (!core_reset_out && !$past(core_reset_out) |-> tx_link_data_out == $past(tx_link_data_in))
        else $error("transmit data not passed through");
    a_irq_pin_low: assert property (host_interrupt_out == 1'b0) else $error("interrupt pin level not low");
    a_reset_vals: assert property ($fell(reset) |-> core_reset_out && host_interrupt_oe_n && !rsp_valid)
        else $error("outputs wrong after hardware reset");
    a_soft_hold: assert property (!$past(reset) && !$past(reset, 2) && core_reset_out && !mem_wr && !$past(mem_wr)
        |=> core_reset_out) else $error("soft reset cleared itself");
    c_cfg: cover property (cfg_hit ##1 rsp_valid);
    c_irq: cover property ($fell(host_interrupt_oe_n));
    c_soft: cover property ($rose(core_reset_out));
endmodule // host_props

// *** bench/host_model.sv ***
// Host side model: one request at a time, answer taken one cycle later
module host_model
    import host_reg_pkg::*;
(
    input wire logic mclk,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    output logic req_valid,
    output logic req_config,
    output logic req_idsel,
    output logic req_write,
    output logic [DATA_W-1:0] req_addr,
    output logic [BE_W-1:0] host_byte_enables_n,
    output logic [DATA_W-1:0] req_wdata
);
    // ----------------------------------------
    // Access task
    // ----------------------------------------
    initial begin
        req_valid = 1'b0;
        req_config = 1'b0;
        req_idsel = 1'b0;
        req_write = 1'b0;
        req_addr = 32'h0;
        host_byte_enables_n = 4'hf;
        req_wdata = 32'h0;
    end
    task automatic access(input logic c, input logic s, input logic w, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] d, output logic ok, output logic [31:0] q);
        @(negedge mclk);
        req_valid = 1'b1;
        req_config = c;
        req_idsel = s;
        req_write = w;
        req_addr = a;
        host_byte_enables_n = be;
        req_wdata = d;
        @(negedge mclk);
        ok = rsp_valid;
        q = c ? rsp_rdata : rsp_rdata & 32'h0000ffff;
        req_valid = 1'b0;
        // Address and data lines flip so a stale value cannot pass for a live one
        req_addr = ~a;
        req_wdata = ~d;
    endtask
endmodule // host_model

// *** bench/tb_top.sv ***
// Self-checking bench for the host register front end
module tb_top
    import host_reg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    localparam logic [31:0] BASE = 32'h00008000;
    typedef struct packed {logic [10:0] o; logic [3:0] be; logic [31:0] wd; logic [31:0] ex;} row_t;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic req_valid, req_config, req_idsel, req_write, rsp_valid, host_interrupt_out, host_interrupt_oe_n;
    logic core_reset_out, got;
    logic [DATA_W-1:0] req_addr, req_wdata, rsp_rdata, tx_link_data_in, tx_link_data_out, rd;
    logic [BE_W-1:0] host_byte_enables_n;
    logic [EVENT_W-1:0] event_in = 16'h0;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    row_t rows [5] = '{'{OFS_INTERRUPT_ENABLE_MASK, 4'h0, 32'h0000a5a5, 32'h0000a5a5},
        '{OFS_INTERRUPT_ENABLE_MASK, 4'he, 32'hffff0000, 32'h0}, '{OFS_INTERRUPT_ENABLE_MASK, 4'h7, 32'h5a5a, 32'h5a5a},
        '{OFS_INTERRUPT_ENABLE_MASK, 4'hf, 32'hffff, 32'h5a5a}, '{OFS_INTERRUPT_STATUS, 4'h0, 32'hffff, 32'h5a5a}};
    always #4 mclk = ~mclk;
    host_register_front uut (.*);
    host_model host (.*);
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        num_checks++;
        if (sn !== ex) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, ex, sn);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic mw(input logic [10:0] o, input logic [31:0] d);
        host.access(1'b0, 1'b0, 1'b1, BASE + {21'h0, o}, 4'h0, d, got, rd);
    endtask
    task automatic mr(input logic [10:0] o);
        host.access(1'b0, 1'b0, 1'b0, BASE + {21'h0, o}, 4'h0, 32'h0, got, rd);
    endtask
    task automatic cw(input logic [7:0] o, input logic [31:0] d);
        host.access(1'b1, 1'b1, 1'b1, {24'h0, o}, 4'h0, d, got, rd);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tx_link_data_in = 32'h5a5a0f0f;
        repeat (16) @(negedge mclk);
        reset = 1'b0;
        cw(CFG_OFS_MEM_BASE, BASE);
        cw(CFG_OFS_COMMAND, 32'h2);
        host.access(1'b1, 1'b1, 1'b0, {24'h0, CFG_OFS_MEM_BASE}, 4'h0, 32'h0, got, rd);
        chk("base", BASE, rd);
        cw(CFG_OFS_INTR, 32'h0000005a);
        host.access(1'b1, 1'b1, 1'b0, {24'h0, CFG_OFS_INTR}, 4'h0, 32'h0, got, rd);
        chk("intr line", {16'h0, INTR_PIN_VALUE, 8'h5a}, rd);
        host.access(1'b1, 1'b1, 1'b0, {24'h0, CFG_OFS_MEM_BASE}, 4'hf, 32'h0, got, rd);
        chk("no be rd", 32'h0, rd);
        chk("no be rsp", 32'h1, {31'h0, got});
        host.access(1'b1, 1'b0, 1'b0, {24'h0, CFG_OFS_IDENT}, 4'h0, 32'h0, got, rd);
        chk("nosel rsp", 32'h0, {31'h0, got});
        host.access(1'b0, 1'b0, 1'b0, BASE ^ 32'h00010000, 4'h0, 32'h0, got, rd);
        chk("miss rsp", 32'h0, {31'h0, got});
        mr(OFS_INTERRUPT_ENABLE_MASK);
        chk("enable reset", 32'h0, rd);
        chk("hit rsp", 32'h1, {31'h0, got});
        chk("tx pass", tx_link_data_in, tx_link_data_out);
        foreach (rows[i]) begin
            host.access(1'b0, 1'b0, 1'b1, BASE + {21'h0, rows[i].o}, rows[i].be, rows[i].wd, got, rd);
            mr(OFS_INTERRUPT_ENABLE_MASK);
            chk("enable", rows[i].ex, rd);
        end
        for (int b = 0; b < 2; b++) begin
            mw(OFS_INTERRUPT_ENABLE_MASK, 32'h1 << b);
            @(negedge mclk);
            event_in = 16'h1 << b;
            @(negedge mclk);
            event_in = 16'h0;
            @(negedge mclk);
            chk("irq on", 32'h0, {31'h0, host_interrupt_oe_n});
            mw(OFS_INTERRUPT_ENABLE_MASK, 32'h0);
            @(negedge mclk);
            chk("irq masked", 32'h1, {31'h0, host_interrupt_oe_n});
            host.access(1'b0, 1'b0, 1'b0, BASE + {21'h0, OFS_INTERRUPT_STATUS}, 4'hf, 32'h0, got, rd);
            chk("no be status", 32'h0, rd);
            mr(OFS_INTERRUPT_STATUS);
            chk("status", 32'h1 << b, rd);
            mr(OFS_INTERRUPT_STATUS);
            chk("status clear", 32'h0, rd);
        end
        mw(OFS_INTERRUPT_ENABLE_MASK, 32'h3);
        mw(OFS_SOFTWARE_RESET_CONTROL, 32'h8000);
        repeat (2) @(negedge mclk);
        chk("core reset", 32'h1, {31'h0, core_reset_out});
        chk("tx high", TX_FORCED_HIGH, tx_link_data_out);
        mr(OFS_SOFTWARE_RESET_CONTROL);
        chk("soft bit", 32'h8000, rd);
        chk("host rsp", 32'h1, {31'h0, got});
        mr(OFS_INTERRUPT_ENABLE_MASK);
        chk("enable soft", 32'h0, rd);
        host.access(1'b1, 1'b1, 1'b0, {24'h0, CFG_OFS_MEM_BASE}, 4'h0, 32'h0, got, rd);
        chk("base kept", BASE, rd);
        mw(OFS_SOFTWARE_RESET_CONTROL, 32'h0);
        repeat (2) @(negedge mclk);
        chk("core run", 32'h0, {31'h0, core_reset_out});
        mw(OFS_SOFTWARE_RESET_CONTROL, 32'h8000);
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
        repeat (2) @(negedge mclk);
        chk("core hw", 32'h0, {31'h0, core_reset_out});
        cw(CFG_OFS_MEM_BASE, BASE);
        cw(CFG_OFS_COMMAND, 32'h2);
        mr(OFS_SOFTWARE_RESET_CONTROL);
        chk("soft bit hw", 32'h0, rd);
        complete_run();
    end
endmodule // tb_top

bind host_register_front host_props u_props (.*);
